/* File: core/usc_uart.sv */
// Serial transceiver with AXI4-Lite register access, transmit and receive queues.
// Assumes queue depths are powers of two and serial_in_pin_i is asynchronous.
// How it works
// RULE_01: Receive polarity bit set makes a low receive line the idle level.
// RULE_02: High-speed bit gives 4 baud ticks per bit, else 16.
// RULE_03: Parity/width field picks 9-bit, 8-bit odd, 8-bit even or 8-bit plain.
// RULE_04: Stop select bit set sends two stop bits, else one.
// RULE_05: Transmit event per mode: queue emptied, all shifted out, or every load.
// RULE_06: Transmit idle level follows polarity bit, sense flipped while codec is on.
// RULE_07: Break request sends start, twelve zeros, stop, then clears itself.
// RULE_08: Clearing transmit enable aborts sending, empties the queue, releases the pin.
// RULE_09: Transmit full flag is one only while the queue is full.
// RULE_10: Transmit done flag is one when shifter and queue are empty.
// RULE_11: Receive event per mode: four queued, three queued, or every character.
// RULE_12: Address detect in 9-bit mode keeps only characters with ninth bit set.
// RULE_13: Receiver idle flag is one unless a character is arriving.
// RULE_14: Parity and framing flags describe the character at the queue head.
// RULE_15: Overrun sets on a full queue; clearing it flushes queue and shifter.
// RULE_16: Data available flag is one while the receive queue holds a character.
// RULE_17: Transmit data takes eight bits low and the ninth bit at bit 8.
// RULE_18: Receive data shows eight bits low, ninth at bit 8, rest zero.
// RULE_19: Module enable off releases all pins and stops the logic.
// RULE_20: Reading receive data moves the next character and its flags up.
// RULE_21: Setting transmit enable raises a transmit event two cycles later.
// RULE_22: Software sends a break by a dummy write, then may queue a sync.
// RULE_23: Characters go out least bit first, parity after data, before stops.
// RULE_24: Receiver samples mid-bit and flags framing when first stop is low.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module usc_fifo #(
   parameter int W = 11,
   parameter int D = 4
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic flush_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [W-1:0] data_i,
   output logic [W-1:0] head_o,
   output logic [$clog2(D):0] cnt_o
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW + 1)'(D);
   logic [W-1:0] mem_reg [D];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   wire do_push = push_i & (cnt_reg != FULL);
   wire do_pop = pop_i & (cnt_reg != '0);
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || flush_i) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg <= wp_reg + AW'(do_push);
         rp_reg <= rp_reg + AW'(do_pop);
         cnt_reg <= cnt_reg + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < D; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (do_push) begin
         mem_reg[wp_reg] <= data_i;
      end
   end
   assign head_o = mem_reg[rp_reg];
   assign cnt_o = cnt_reg;
endmodule

module usc_uart #(
   parameter int TX_DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [4:0] s_axi_awaddr_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [4:0] s_axi_araddr_i,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   input wire logic serial_in_pin_i,
   output logic serial_out_pin_o,
   output logic serial_out_oe_o,
   output logic [1:0] pin_usage_o,
   output logic tx_irq_o,
   output logic rx_irq_o
);
   import usc_pkg::*;
   localparam int RXD = 4;
   localparam int TAW = $clog2(TX_DEPTH);

   function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [3:0] st, input logic [15:0] m);
      logic [15:0] lane;
      lane = {{8{st[1]}}, {8{st[0]}}} & m;
      return (old & ~lane) | (wd & lane);
   endfunction

   // ==========================================================
   // Register bus
   logic [15:0] mode_reg;
   logic [15:0] stat_reg;
   logic [15:0] baud_reg;
   logic overrun_flag_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [TAW:0] tx_cnt;
   logic [8:0] tx_head;
   logic [2:0] rx_cnt;
   logic [10:0] rx_head;
   logic tx_done;
   logic brk_act_reg;
   usc_tx_state_t tx_st_reg;
   usc_rx_state_t rx_st_reg;

   wire wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_reg;
   wire rd_go = s_axi_arvalid_i & ~rvalid_reg;
   wire wr_mode = wr_go & (s_axi_awaddr_i == ADDR_MODE);
   wire wr_stat = wr_go & (s_axi_awaddr_i == ADDR_STAT);
   wire wr_txd = wr_go & (s_axi_awaddr_i == ADDR_TXD) & (|s_axi_wstrb_i[1:0]);
   wire wr_baud = wr_go & (s_axi_awaddr_i == ADDR_BAUD);
   wire wr_hit = wr_mode | wr_stat | wr_baud | (wr_go & (s_axi_awaddr_i == ADDR_TXD));
   wire rd_rxd = rd_go & (s_axi_araddr_i == ADDR_RXD);
   wire [15:0] wd16 = s_axi_wdata_i[15:0];

   wire en = mode_reg[MD_EN];
   wire nine = mode_reg[MD_PD_LO+:2] == PD_9N;
   wire par_on = ^mode_reg[MD_PD_LO+:2];
   wire odd_sel = mode_reg[MD_PD_LO+1];
   wire txen = stat_reg[ST_TXEN];
   wire brk = stat_reg[ST_BRK];
   wire [1:0] txis = {stat_reg[ST_TXIS1], stat_reg[ST_TXIS0]};
   wire [1:0] rxis = stat_reg[ST_RXIS_LO+:2];
   wire tx_full = tx_cnt == (TAW + 1)'(TX_DEPTH);
   wire tx_empty = tx_cnt == '0;
   wire rx_empty = rx_cnt == '0;
   wire tx_all_done = tx_empty & (tx_st_reg == USC_TX_IDLE);
   wire rx_idle_flag = rx_st_reg == USC_RX_IDLE;
   // RULE_15 Overrun clear flush
   wire overrun_flag_clr = wr_stat & s_axi_wstrb_i[0] & ~wd16[ST_OVERRUN_FLAG] & overrun_flag_reg;
   // RULE_14 Head error flags
   wire parity_error_flag_h = rx_head[9] & ~rx_empty;
   wire framing_error_flag_h = rx_head[10] & ~rx_empty;
   // RULE_09 RULE_10 RULE_13 RULE_16 Status image
   wire [15:0] stat_rd = {stat_reg[15:13], 1'b0, stat_reg[11:10], tx_full, tx_all_done,
                          stat_reg[7:5], rx_idle_flag, parity_error_flag_h, framing_error_flag_h, overrun_flag_reg, ~rx_empty};
   // RULE_18 Receive data image
   wire [15:0] rxd_rd = {7'h00, rx_head[8:0]};
   wire [15:0] rd_mux = (s_axi_araddr_i == ADDR_MODE) ? mode_reg :
                        (s_axi_araddr_i == ADDR_STAT) ? stat_rd :
                        (s_axi_araddr_i == ADDR_RXD) ? rxd_rd :
                        (s_axi_araddr_i == ADDR_BAUD) ? baud_reg : 16'h0000;
   wire rd_hit = (s_axi_araddr_i == ADDR_MODE) | (s_axi_araddr_i == ADDR_STAT) |
                 (s_axi_araddr_i == ADDR_RXD) | (s_axi_araddr_i == ADDR_BAUD) |
                 (s_axi_araddr_i == ADDR_TXD);

   // RULE_07 Break request self clear
   wire [15:0] stat_next = wr_stat ? wmerge(stat_reg, wd16, s_axi_wstrb_i, STAT_WMASK) :
                           (tx_done & brk_act_reg) ? (stat_reg & ~(16'h0001 << ST_BRK)) :
                           stat_reg;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mode_reg <= MODE_RST;
         stat_reg <= STAT_RST;
         baud_reg <= BAUD_RST;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else begin
         if (wr_mode) begin
            mode_reg <= wmerge(mode_reg, wd16, s_axi_wstrb_i, MODE_WMASK);
         end
         if (wr_baud) begin
            baud_reg <= wmerge(baud_reg, wd16, s_axi_wstrb_i, 16'hffff);
         end
         stat_reg <= stat_next;
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
         end
         if (rd_go) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {16'h0000, rd_mux};
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_awready_o = wr_go;
   assign s_axi_wready_o = wr_go;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = ~rvalid_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;

   // ==========================================================
   // Baud generator
   logic [15:0] div_reg;
   wire tick = en & (div_reg == baud_reg);
   // RULE_02 Oversampling rate
   wire [4:0] ovs_max = mode_reg[MD_HIGH_SPEED_OVERSAMPLE_SEL] ? OVS_HI - 5'h01 : OVS_STD - 5'h01;
   wire [4:0] ovs_mid = mode_reg[MD_HIGH_SPEED_OVERSAMPLE_SEL] ? OVS_HI >> 1 : OVS_STD >> 1;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || tick || !en) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Transmitter
   logic txen_q_reg;
   logic [1:0] txen_pipe_reg;
   logic [15:0] frame_reg;
   logic [4:0] bits_reg;
   logic [4:0] tx_ovs_reg;
   logic tx_irq_reg;
   logic out_reg;
   logic oe_reg;
   // RULE_08 Abort on disable
   wire tx_flush = (txen_q_reg & ~txen) | ~en;
   wire tx_load = en & txen & ~tx_empty & (tx_st_reg == USC_TX_IDLE);
   wire bit_end = tick & (tx_ovs_reg == ovs_max);
   assign tx_done = bit_end & (bits_reg == 5'h01) & (tx_st_reg == USC_TX_SHIFT);
   // RULE_23 RULE_03 Frame with parity slot
   wire pbit = (^tx_head[7:0]) ^ odd_sel;
   wire slot = nine ? tx_head[8] : (par_on ? pbit : 1'b1);
   wire [15:0] frame_n = {6'h3f, slot, tx_head[7:0], 1'b0};
   // RULE_04 Stop count
   wire [4:0] len_n = LEN_BASE + 5'(nine | par_on) + 5'(mode_reg[MD_STOP_COUNT_SEL]);

   // RULE_17 Transmit data capture
   usc_fifo #(.W(9), .D(TX_DEPTH)) u_txq (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .flush_i(tx_flush),
      .push_i(wr_txd),
      .pop_i(tx_load),
      .data_i(wd16[8:0]),
      .head_o(tx_head),
      .cnt_o(tx_cnt)
   );

   always_ff @(posedge clk_i) begin
      if (sys_rst_i || tx_flush) begin
         tx_st_reg <= USC_TX_IDLE;
         frame_reg <= 16'hffff;
         bits_reg <= '0;
         tx_ovs_reg <= '0;
         brk_act_reg <= 1'b0;
      end else if (tx_load) begin
         tx_st_reg <= USC_TX_SHIFT;
         tx_ovs_reg <= '0;
         brk_act_reg <= brk;
         // RULE_07 Break frame
         frame_reg <= brk ? 16'hffff << (BRK_ZEROS + 1) : frame_n;
         bits_reg <= brk ? BRK_LEN : len_n;
      end else if (tx_st_reg == USC_TX_SHIFT && tick) begin
         tx_ovs_reg <= bit_end ? 5'h00 : tx_ovs_reg + 5'h01;
         if (bit_end) begin
            frame_reg <= {1'b1, frame_reg[15:1]};
            bits_reg <= bits_reg - 5'h01;
            if (bits_reg == 5'h01) begin
               tx_st_reg <= USC_TX_IDLE;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         txen_q_reg <= 1'b0;
         txen_pipe_reg <= '0;
         tx_irq_reg <= 1'b0;
         out_reg <= 1'b1;
         oe_reg <= 1'b0;
      end else begin
         txen_q_reg <= txen;
         // RULE_21 Enable event delay
         txen_pipe_reg <= {txen_pipe_reg[0], txen & ~txen_q_reg};
         // RULE_05 Transmit event modes
         tx_irq_reg <= (tx_load & (txis == TXI_EACH)) |
                       (tx_load & (txis == TXI_EMPTY) & (tx_cnt == (TAW + 1)'(1))) |
                       (tx_done & (txis == TXI_DONE) & tx_empty);
         // RULE_06 Idle level sense
         out_reg <= ((tx_st_reg == USC_TX_SHIFT) ? frame_reg[0] : 1'b1) ^
                    stat_reg[ST_TXINV] ^ mode_reg[MD_INFRARED_CODEC_ON];
         // RULE_08 RULE_19 Pin ownership
         oe_reg <= en & txen;
      end
   end
   assign tx_irq_o = tx_irq_reg | txen_pipe_reg[TXEN_IRQ_DLY-1];
   assign serial_out_pin_o = out_reg;
   assign serial_out_oe_o = oe_reg;
   assign pin_usage_o = en ? mode_reg[MD_PIN_LO+:2] : 2'h0;

   // ==========================================================
   // Receiver
   logic [2:0] sync_reg;
   logic filt_reg;
   logic [4:0] rx_ovs_reg;
   logic [4:0] idx_reg;
   logic [8:0] sh_reg;
   logic rx_irq_reg;
   // RULE_01 Receive polarity
   wire line = filt_reg ^ mode_reg[MD_RX_IDLE_POLARITY];
   wire samp = tick & (rx_ovs_reg == ovs_mid) & (rx_st_reg == USC_RX_RUN);
   wire [4:0] stop_idx = LEN_BASE - 5'h01 + 5'(nine | par_on);
   wire at_stop = samp & (idx_reg == stop_idx);
   wire slot_rx = nine | par_on;
   wire [7:0] rx_d8 = slot_rx ? sh_reg[7:0] : sh_reg[8:1];
   wire rx_parity_error_flag = par_on & (sh_reg[8] ^ (^rx_d8) ^ odd_sel);
   // RULE_12 Address filter
   wire accept = ~(stat_reg[ST_ADDRESS_DETECT_ON] & nine & ~sh_reg[8]);
   wire rx_full = rx_cnt == 3'(RXD);
   wire rx_push = at_stop & accept & ~rx_full;
   wire rx_ovf = at_stop & accept & rx_full;
   wire rx_flush = overrun_flag_clr | ~en;

   // RULE_20 Read advances head
   usc_fifo #(.W(11), .D(RXD)) u_rxq (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .flush_i(rx_flush),
      .push_i(rx_push),
      .pop_i(rd_rxd),
      .data_i({~line, rx_parity_error_flag, nine & sh_reg[8], rx_d8}),
      .head_o(rx_head),
      .cnt_o(rx_cnt)
   );

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync_reg <= 3'h7;
         filt_reg <= 1'b1;
      end else begin
         sync_reg <= {sync_reg[1:0], serial_in_pin_i};
         if (sync_reg[1] == sync_reg[2]) begin
            filt_reg <= sync_reg[2];
         end
      end
   end

   // RULE_24 Mid-bit sampling
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || rx_flush) begin
         rx_st_reg <= USC_RX_IDLE;
         rx_ovs_reg <= '0;
         idx_reg <= '0;
         sh_reg <= '0;
      end else if (rx_st_reg == USC_RX_IDLE) begin
         if (!line) begin
            rx_st_reg <= USC_RX_RUN;
            rx_ovs_reg <= '0;
            idx_reg <= '0;
         end
      end else if (tick) begin
         rx_ovs_reg <= (rx_ovs_reg == ovs_max) ? 5'h00 : rx_ovs_reg + 5'h01;
         if (samp) begin
            idx_reg <= idx_reg + 5'h01;
            if ((idx_reg == '0 && line) || at_stop) begin
               rx_st_reg <= USC_RX_IDLE;
            end else if (idx_reg != '0) begin
               sh_reg <= {line, sh_reg[8:1]};
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         overrun_flag_reg <= 1'b0;
         rx_irq_reg <= 1'b0;
      end else begin
         // RULE_15 Overrun set wins
         overrun_flag_reg <= rx_ovf | (overrun_flag_reg & ~overrun_flag_clr);
         // RULE_11 Receive event modes
         rx_irq_reg <= rx_push & (~rxis[1] |
                       ((rxis == RXI_FULL) ? (rx_cnt + 3'h1 == RX_LVL_FULL) :
                                             (rx_cnt + 3'h1 == RX_LVL_3Q)));
      end
   end
   assign rx_irq_o = rx_irq_reg;

   // ==========================================================
   // Checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   chk_txbf_cause: assert property ($rose(tx_full) |-> $past(wr_txd)) // RULE_09
      else $error("full flag rose without a write");
   chk_tx_all_done_busy: assert property ((tx_st_reg == USC_TX_SHIFT) |-> !stat_rd[8]) // RULE_10
      else $error("done flag high while shifting");
   chk_txen_event: assert property ($rose(txen) |-> ##2 tx_irq_o) // RULE_21
      else $error("no transmit event after enable");
   chk_break_len: assert property ((tx_load && brk) |=> bits_reg == BRK_LEN) // RULE_07
      else $error("break frame length wrong");
   chk_txen_abort: assert property ($fell(txen) |=> tx_st_reg == USC_TX_IDLE) // RULE_08
      else $error("transmit not aborted");
   chk_overrun_flag_flush: assert property ((overrun_flag_clr && !rx_ovf) |=> rx_empty && !overrun_flag_reg) // RULE_15
      else $error("overrun clear did not flush");
   chk_rx_each: assert property ((rx_push && !rxis[1]) |=> rx_irq_o) // RULE_11
      else $error("receive event missing");
   chk_rxda_level: assert property ((rx_push && rx_empty) |=> stat_rd[0]) // RULE_16
      else $error("data available not set");
   cov_break: cover property (tx_load && brk);
   cov_overrun: cover property (rx_ovf);
   cov_parity_error_flag: cover property (rx_push && rx_parity_error_flag);
endmodule

/* File: core/usc_pkg.sv */
// Shared constants and types of the serial transceiver register block.
// Assumes a 16-bit register image carried in the low half of a 32-bit bus.
package usc_pkg;
   // ==========================================================
   // Register byte addresses
   localparam logic [4:0] ADDR_MODE = 5'h00;
   localparam logic [4:0] ADDR_STAT = 5'h04;
   localparam logic [4:0] ADDR_TXD = 5'h08;
   localparam logic [4:0] ADDR_RXD = 5'h0c;
   localparam logic [4:0] ADDR_BAUD = 5'h10;
   // ==========================================================
   // Mode register fields
   localparam int MD_EN = 15;
   localparam int MD_INFRARED_CODEC_ON = 12;
   localparam int MD_PIN_LO = 8;
   localparam int MD_RX_IDLE_POLARITY = 4;
   localparam int MD_HIGH_SPEED_OVERSAMPLE_SEL = 3;
   localparam int MD_PD_LO = 1;
   localparam int MD_STOP_COUNT_SEL = 0;
   localparam logic [15:0] MODE_WMASK = 16'h931f;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] BAUD_RST = 16'h0000;
   // ==========================================================
   // Status and control fields
   localparam int ST_TXIS1 = 15;
   localparam int ST_TXINV = 14;
   localparam int ST_TXIS0 = 13;
   localparam int ST_BRK = 11;
   localparam int ST_TXEN = 10;
   localparam int ST_RXIS_LO = 6;
   localparam int ST_ADDRESS_DETECT_ON = 5;
   localparam int ST_OVERRUN_FLAG = 1;
   localparam logic [15:0] STAT_WMASK = 16'hece0;
   localparam logic [15:0] STAT_RST = 16'h0000;
   // ==========================================================
   // Codes
   localparam logic [1:0] PD_9N = 2'h3;
   localparam logic [1:0] TXI_EMPTY = 2'h2;
   localparam logic [1:0] TXI_DONE = 2'h1;
   localparam logic [1:0] TXI_EACH = 2'h0;
   localparam logic [1:0] RXI_FULL = 2'h3;
   localparam logic [2:0] RX_LVL_FULL = 3'h4;
   localparam logic [2:0] RX_LVL_3Q = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Timing
   localparam logic [4:0] OVS_HI = 5'h04;
   localparam logic [4:0] OVS_STD = 5'h10;
   localparam int BRK_ZEROS = 12;
   localparam logic [4:0] LEN_BASE = 5'h0a;
   localparam logic [4:0] BRK_LEN = 5'(BRK_ZEROS + 2);
   localparam int TXEN_IRQ_DLY = 2;
   typedef enum logic {USC_TX_IDLE = 1'b0, USC_TX_SHIFT = 1'b1} usc_tx_state_t;
   typedef enum logic {USC_RX_IDLE = 1'b0, USC_RX_RUN = 1'b1} usc_rx_state_t;
endpackage

/* File: tb/usc_node.sv */
// Remote serial node model on the transceiver's line pins.
// Assumes the bench passes the bit period in clock cycles.
`timescale 1ns/1ps
module usc_node (
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic oe_i,
   output logic line_o
);
   // ==========================================================
   // Sender, line held high between frames
   initial line_o = 1'b1;
   task automatic send(input logic [15:0] fr, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         line_o <= fr[i];
         repeat (per) @(posedge clk_i);
      end
      line_o <= 1'b1;
      repeat (per) @(posedge clk_i);
   endtask
   // ==========================================================
   // Capture from start bit, one sample mid-bit
   task automatic grab(output logic [15:0] fr, input int n, input int per);
      int k;
      fr = 16'h0000;
      k = 0;
      while (!(oe_i === 1'b1 && line_i === 1'b0) && k < 3000) begin
         @(posedge clk_i);
         k++;
      end
      repeat (per / 2 - 1) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         fr[i] = line_i;
         if (i < n - 1) repeat (per) @(posedge clk_i);
      end
   endtask
endmodule

/* File: tb/usc_uart_tb.sv */
// Bench of the serial transceiver: register master and scenarios.
// Assumes usc_pkg and the node model are compiled first.
`timescale 1ns/1ps
module uart_status_control_data_regs_tb_top;
   import usc_pkg::*;
   logic clk_i, sys_rst_i, awv, wv, arv, rx_pin, tx_pin, oe, awr, wrd, bv, arr, rv, tx_irq, rx_irq;
   logic [4:0] awa, ara;
   logic [1:0] br, rr, pins, resp;
   logic [31:0] wd, rdat, d, rx_ev, e0, tx_ev;
   logic [15:0] f;
   int bad_count, n_checks;
   localparam logic [15:0] TMD [4] = '{16'h800b, 16'h800c, 16'h800e, 16'h8008};
   localparam logic [15:0] TEX [4] = '{16'h0f48, 16'h0d48, 16'h0f48, 16'h0f48};
   usc_uart i_usc_uart (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h3), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
      .s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
      .serial_in_pin_i(rx_pin), .serial_out_pin_o(tx_pin), .serial_out_oe_o(oe),
      .pin_usage_o(pins), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
   usc_node i_usc_node (.clk_i(clk_i), .line_i(tx_pin), .oe_i(oe), .line_o(rx_pin));
   // ==========================================================
   // Clock and event counters
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (rx_irq === 1'b1) rx_ev <= rx_ev + 32'h1;
   always @(posedge clk_i) if (tx_irq === 1'b1) tx_ev <= tx_ev + 32'h1;
   // ==========================================================
   // Verdict and comparison
   task automatic end_sim();
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic tmo();
      bad_count++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // ==========================================================
   // Register bus master
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      int k;
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= {16'h0000, v};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (awr !== 1'b1 && k < 50);
      awv <= 1'b0;
      wv <= 1'b0;
      do begin
         @(posedge clk_i);
         k++;
      end while (bv !== 1'b1 && k < 100);
      if (k >= 100) tmo();
      resp = br;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      int k;
      arv <= 1'b1;
      ara <= a;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (arr !== 1'b1 && k < 50);
      arv <= 1'b0;
      do begin
         @(posedge clk_i);
         k++;
      end while (rv !== 1'b1 && k < 100);
      if (k >= 100) tmo();
      q = rdat;
      resp = rr;
   endtask
   task automatic poll(input int b);
      int k;
      k = 0;
      do begin
         rd(ADDR_STAT, d);
         k++;
      end while (d[b] !== 1'b1 && k < 300);
      if (k >= 300) tmo();
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rd(ADDR_STAT, d);
      chk(d, 32'h00000110);
      wr(ADDR_MODE, 16'hffff);
      rd(ADDR_MODE, d);
      chk(d, {16'h0000, MODE_WMASK});
      chk({30'h0, pins}, 32'h3);
      wr(ADDR_MODE, 16'h0000);
      rd(ADDR_TXD, d);
      chk(d, 32'h0);
      rd(5'h14, d);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
   endtask
   task automatic t_tx();
      e0 = tx_ev;
      wr(ADDR_STAT, 16'h0400);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_MODE, TMD[i]);
         fork
            i_usc_node.grab(f, 12, 4);
            wr(ADDR_TXD, 16'h01a4);
         join
         chk({16'h0, f}, {16'h0, TEX[i]});
         poll(8);
         chk(d, 32'h00000510);
      end
      chk(tx_ev - e0, 32'h5);
      wr(ADDR_STAT, 16'h2400);
      e0 = tx_ev;
      wr(ADDR_TXD, 16'h0033);
      poll(8);
      chk(tx_ev - e0, 32'h1);
      wr(ADDR_STAT, 16'h8400);
      e0 = tx_ev;
      wr(ADDR_TXD, 16'h0033);
      poll(8);
      chk(tx_ev - e0, 32'h1);
   endtask
   task automatic t_break();
      logic [15:0] g;
      wr(ADDR_STAT, 16'h0c00);
      fork
         begin
            i_usc_node.grab(f, 14, 4);
            i_usc_node.grab(g, 10, 4);
         end
         begin
            wr(ADDR_TXD, 16'h00ff);
            wr(ADDR_TXD, 16'h0055);
         end
      join
      chk({16'h0, f}, 32'h00002000);
      chk({16'h0, g}, 32'h000002aa);
      poll(8);
      chk(d, 32'h00000510);
      wr(ADDR_STAT, 16'h4400);
      repeat (2) @(posedge clk_i);
      chk({31'h0, tx_pin}, 32'h0);
      wr(ADDR_MODE, 16'h9008);
      repeat (2) @(posedge clk_i);
      chk({31'h0, tx_pin}, 32'h1);
   endtask
   task automatic t_abort();
      wr(ADDR_STAT, 16'h0000);
      for (int i = 0; i < 4; i++) wr(ADDR_TXD, 16'h0011);
      rd(ADDR_STAT, d);
      chk(d, 32'h00000210);
      wr(ADDR_STAT, 16'h0400);
      wr(ADDR_STAT, 16'h0000);
      rd(ADDR_STAT, d);
      chk(d, 32'h00000110);
      chk({31'h0, oe}, 32'h0);
   endtask
   task automatic t_rx();
      wr(ADDR_MODE, 16'h8002);
      i_usc_node.send(16'h06aa, 11, 16);
      i_usc_node.send(16'h04b4, 11, 16);
      poll(0);
      chk(d, 32'h00000119);
      rd(ADDR_RXD, d);
      chk(d, 32'h00000055);
      rd(ADDR_STAT, d);
      chk(d, 32'h00000111);
      rd(ADDR_RXD, d);
      chk(d, 32'h0000005a);
      wr(ADDR_MODE, 16'h8006);
      wr(ADDR_STAT, 16'h0020);
      i_usc_node.send(16'h0586, 11, 16);
      i_usc_node.send(16'h0786, 11, 16);
      poll(0);
      rd(ADDR_RXD, d);
      chk(d, 32'h000001c3);
      rd(ADDR_STAT, d);
      chk(d, 32'h00000130);
   endtask
   task automatic t_ovr();
      wr(ADDR_MODE, 16'h8000);
      wr(ADDR_STAT, 16'h00c0);
      e0 = rx_ev;
      for (int i = 0; i < 5; i++) i_usc_node.send(16'h0200 | 16'(2 * i), 10, 16);
      rd(ADDR_STAT, d);
      chk(d, 32'h000001d3);
      chk(rx_ev - e0, 32'h1);
      wr(ADDR_STAT, 16'h00c0);
      rd(ADDR_STAT, d);
      chk(d, 32'h000001d0);
      wr(ADDR_STAT, 16'h0080);
      e0 = rx_ev;
      for (int i = 0; i < 3; i++) i_usc_node.send(16'h0200 | 16'(2 * i), 10, 16);
      chk(rx_ev - e0, 32'h1);
   endtask
   initial begin
      sys_rst_i = 1'b1;
      awv = 1'b0;
      wv = 1'b0;
      arv = 1'b0;
      awa = 5'h00;
      ara = 5'h00;
      wd = 32'h0;
      rx_ev = 32'h0;
      tx_ev = 32'h0;
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_tx();
      t_break();
      t_abort();
      t_rx();
      t_ovr();
      end_sim();
   end
endmodule
